// *** include/lid_pkg.sv ***
// Purpose: Shared constants and types for the instruction decoder link.
// Assumes: 200 MHz system clock on both ends.
// Notes: Register addresses are the 4-bit instruction address field.
package lid_pkg;
   // Timing of the host strobes, in ns and in cycles.
   localparam int CLK_PERIOD_NS = 5;
   localparam int SETUP_NS = 10;
   localparam int STROBE_NS = 40;
   localparam int RECOVER_NS = 20;
   localparam int SETUP_CYCLES = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STROBE_CYCLES =
      (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RECOVER_CYCLES =
      (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Instruction tables.
   localparam logic [2:0] TABLE_0 = 3'h0;
   localparam logic [2:0] TABLE_1 = 3'h1;
   localparam logic [2:0] TABLE_4 = 3'h4;
   localparam logic [2:0] TABLE_5 = 3'h5;
   // Table 0 register addresses.
   localparam logic [3:0] ADDR_WIN_COL_LO = 4'h0;
   localparam logic [3:0] ADDR_WIN_COL_HI = 4'h1;
   localparam logic [3:0] ADDR_WIN_ROW_LO = 4'h2;
   localparam logic [3:0] ADDR_WIN_ROW_HI = 4'h3;
   localparam logic [3:0] ADDR_FIRST_LO = 4'h4;
   localparam logic [3:0] ADDR_FIRST_HI = 4'h5;
   localparam logic [3:0] ADDR_INV_LO = 4'h6;
   localparam logic [3:0] ADDR_INV_HI = 4'h7;
   localparam logic [3:0] ADDR_DISP_CTL1 = 4'h8;
   localparam logic [3:0] ADDR_DISP_CTL2 = 4'h9;
   localparam logic [3:0] ADDR_SCAN_STEP = 4'ha;
   localparam logic [3:0] ADDR_POWER = 4'hb;
   localparam logic [3:0] ADDR_DUTY = 4'hc;
   localparam logic [3:0] ADDR_BOOST = 4'hd;
   localparam logic [3:0] ADDR_BIAS = 4'he;
   localparam logic [3:0] ADDR_TABLE_SEL = 4'hf;
   // Table 4 contrast halves and table 5 bank select.
   localparam logic [3:0] ADDR_CONTRAST_LO = 4'ha;
   localparam logic [3:0] ADDR_CONTRAST_HI = 4'hb;
   localparam logic [3:0] ADDR_BANK_SEL = 4'h9;
   // Palette layout: three groups of sixteen 5-bit entries.
   localparam logic [4:0] PAL_PAIRS_PER_TABLE = 5'h07;
   localparam logic [4:0] PAL_PAIRS = 5'h18;
   localparam logic [3:0] PAL_LAST_ADDR = 4'hd;
   localparam int PAL_ENTRIES = 48;
   // Host command registers on APB.
   localparam logic [31:0] HOST_CMD_OFS = 32'h0000_0000;
   localparam logic [31:0] HOST_STATUS_OFS = 32'h0000_0004;
   localparam int CMD_FLAG_BIT = 8;
   localparam int CMD_READ_BIT = 9;
   localparam int STATUS_BUSY_BIT = 8;

   typedef struct packed {
      logic [7:0] win_start_col;
      logic [6:0] win_start_row;
      logic [6:0] top_row_pointer;
      logic [6:0] inversion_count;
      logic com_scan_direction;
      logic two_tone_select;
      logic force_pixels_on;
      logic display_enable;
      logic invert_display;
      logic line_group_inversion_en;
      logic palette_exchange;
      logic rmw_flag;
      logic walk_axis;
      logic col_step_dir;
      logic row_step_dir;
      logic bias_amp_enable;
      logic halt;
      logic booster_enable;
      logic [3:0] duty_code;
      logic [2:0] boost_level_code;
      logic [2:0] bias_code;
      logic test_flag;
      logic [2:0] table_index;
      logic palette_bank_select;
      logic [6:0] contrast_resistor;
   } lid_cfg_t;
endpackage

// *** include/lid_bus_if.sv ***
// Purpose: Parallel 8-bit host bus between controller and display driver.
// Assumes: Both ends run on the same clk; the data bus is resolved here.
// Notes: An undriven bus reads as all ones, as if pulled up.
`timescale 1ns/100ps
interface lid_bus_if;
   logic chip_select_n;
   logic cmd_or_data_flag;
   logic read_strobe_n;
   logic write_strobe_n;
   logic [7:0] host_data;
   logic host_data_oe_n;
   logic [7:0] dev_data;
   logic dev_data_oe_n;
   logic [7:0] data;

   assign data = !host_data_oe_n ? host_data :
                 (!dev_data_oe_n ? dev_data : 8'hff);

   modport host (
      output chip_select_n, cmd_or_data_flag, read_strobe_n,
      output write_strobe_n, host_data, host_data_oe_n,
      input data
   );
   modport device (
      input chip_select_n, cmd_or_data_flag, read_strobe_n,
      input write_strobe_n, data,
      output dev_data, dev_data_oe_n
   );
endinterface

// *** hdl/lid_device.sv ***
// Purpose: Display driver end: decodes instruction writes into settings.
// Assumes: Bus pins arrive asynchronously and are synchronised here.
// Notes: A byte is committed on the rising edge of the write strobe.
//
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
module lid_device
   import lid_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // Host bus
   lid_bus_if.device bus,
   // Display memory side
   input wire logic [7:0] display_read_data,
   output logic display_write_pulse,
   output logic [7:0] display_write_data,
   output logic display_read_pulse,
   // Settings
   output lid_pkg::lid_cfg_t cfg,
   output logic [lid_pkg::PAL_ENTRIES-1:0][4:0] palette,
   output logic soft_reset_pulse
);
   import lid_pkg::*;

   typedef struct packed {
      logic [11:0] pins_meta;
      logic [11:0] pins;
      logic wr_prev;
      logic rd_prev;
      logic [7:0] held;
      logic held_cmd;
      logic held_dat;
      logic [2:0] contrast_hi;
      lid_cfg_t cfg;
      logic [PAL_ENTRIES-1:0][4:0] palette;
      logic wr_pulse;
      logic [7:0] wr_data;
      logic rd_pulse;
      logic srst_req;
      logic [7:0] dout;
      logic doe_n;
   } lid_dev_state_t;

   lid_dev_state_t st;
   lid_dev_state_t next_st;

   logic cs_n;
   logic is_cmd;
   logic rd_n;
   logic wr_n;
   logic [7:0] din;
   logic [3:0] addr;
   logic [3:0] val;
   logic [4:0] pair;
   logic [5:0] entry;

   // Only the second synchroniser stage is ever decoded.
   assign {cs_n, is_cmd, rd_n, wr_n, din} = st.pins;
   assign addr = st.held[7:4];
   assign val = st.held[3:0];
   assign pair = 5'((st.cfg.table_index - TABLE_1) * PAL_PAIRS_PER_TABLE)
                 + {2'h0, addr[3:1]};
   assign entry = {pair[4:3], st.cfg.palette_bank_select, pair[2:0]};

   always_comb
   begin
      next_st = st;
      next_st.pins_meta = {bus.chip_select_n, bus.cmd_or_data_flag,
                           bus.read_strobe_n, bus.write_strobe_n, bus.data};
      next_st.pins = st.pins_meta;
      next_st.wr_prev = wr_n;
      next_st.rd_prev = rd_n;
      next_st.wr_pulse = 1'b0;
      next_st.rd_pulse = 1'b0;
      next_st.srst_req = 1'b0;
      // Capture while the strobe is low so the byte is stable at commit.
      if (!wr_n)
      begin
         next_st.held = din;
         next_st.held_cmd = !cs_n && is_cmd && rd_n;
         next_st.held_dat = !cs_n && !is_cmd && rd_n;
      end
      // Data reads are served in any table.
      next_st.doe_n = !(!cs_n && !rd_n && wr_n);
      next_st.dout = is_cmd ? {4'h0, st.cfg.test_flag, st.cfg.table_index}
                        : display_read_data;
      if (!cs_n && !is_cmd && !rd_n && wr_n && st.rd_prev)
      begin
         next_st.rd_pulse = 1'b1;
      end
      if (wr_n && !st.wr_prev && st.held_dat)
      begin
         next_st.wr_pulse = 1'b1;
         next_st.wr_data = st.held;
      end
      // Each write takes effect at once except contrast HI, which is held until the LO write; the table persists.
      if (wr_n && !st.wr_prev && st.held_cmd)
      begin
         if (addr == ADDR_TABLE_SEL)
         begin
            next_st.cfg.test_flag = val[3];
            next_st.cfg.table_index = val[2:0];
         end
         else if (st.cfg.table_index == TABLE_0)
         begin
            if (addr == ADDR_WIN_COL_LO)
               next_st.cfg.win_start_col[3:0] = val;
            else if (addr == ADDR_WIN_COL_HI)
               next_st.cfg.win_start_col[7:4] = val;
            else if (addr == ADDR_WIN_ROW_LO)
               next_st.cfg.win_start_row[3:0] = val;
            else if (addr == ADDR_WIN_ROW_HI)
               next_st.cfg.win_start_row[6:4] = val[2:0];
            else if (addr == ADDR_FIRST_LO)
               next_st.cfg.top_row_pointer[3:0] = val;
            else if (addr == ADDR_FIRST_HI)
               next_st.cfg.top_row_pointer[6:4] = val[2:0];
            else if (addr == ADDR_INV_LO)
               next_st.cfg.inversion_count[3:0] = val;
            else if (addr == ADDR_INV_HI)
               next_st.cfg.inversion_count[6:4] = val[2:0];
            else if (addr == ADDR_DISP_CTL1)
            begin
               next_st.cfg.com_scan_direction = val[3];
               next_st.cfg.two_tone_select = val[2];
               next_st.cfg.force_pixels_on = val[1];
               next_st.cfg.display_enable = val[0];
            end
            else if (addr == ADDR_DISP_CTL2)
            begin
               next_st.cfg.invert_display = val[3];
               next_st.cfg.line_group_inversion_en = val[2];
               next_st.cfg.palette_exchange = val[1];
            end
            else if (addr == ADDR_SCAN_STEP)
            begin
               next_st.cfg.rmw_flag = val[3];
               next_st.cfg.walk_axis = val[2];
               next_st.cfg.col_step_dir = val[1];
               next_st.cfg.row_step_dir = val[0];
            end
            else if (addr == ADDR_POWER)
            begin
               next_st.cfg.bias_amp_enable = val[3];
               next_st.cfg.halt = val[2];
               next_st.cfg.booster_enable = val[1];
               next_st.srst_req = val[0];
            end
            else if (addr == ADDR_DUTY)
               next_st.cfg.duty_code = val;
            else if (addr == ADDR_BOOST)
               next_st.cfg.boost_level_code = val[2:0];
            else if (addr == ADDR_BIAS)
               next_st.cfg.bias_code = val[2:0];
         end
         else if (st.cfg.table_index == TABLE_5)
         begin
            if (addr == ADDR_BANK_SEL)
               next_st.cfg.palette_bank_select = val[0];
         end
         else if (st.cfg.table_index == TABLE_4 && addr == ADDR_CONTRAST_HI)
            next_st.contrast_hi = val[2:0];
         else if (st.cfg.table_index == TABLE_4 && addr == ADDR_CONTRAST_LO)
            next_st.cfg.contrast_resistor = {st.contrast_hi, val};
         else if (addr <= PAL_LAST_ADDR && pair < PAL_PAIRS)
         begin
            // Other codes in these tables are never sent by the host.
            if (!addr[0])
               next_st.palette[entry][3:0] = val;
            else
               next_st.palette[entry][4] = val[0];
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st <= '0;
         st.pins_meta <= 12'hfff;
         st.pins <= 12'hfff;
         st.wr_prev <= 1'b1;
         st.rd_prev <= 1'b1;
         st.doe_n <= 1'b1;
         // Default palette: entry j holds {j mod 16, 1}; entries 0, 16 and 32 hold zero.
         for (int i = 1; i < PAL_ENTRIES; i++)
         begin
            st.palette[i] <= (i % 16 == 0) ? 5'h00 : {4'(i % 16), 1'b1};
         end
      end
      else if (clk_en)
      begin
         st <= next_st;
      end
   end

   assign display_write_pulse = st.wr_pulse;
   assign display_write_data = st.wr_data;
   assign display_read_pulse = st.rd_pulse;
   assign cfg = st.cfg;
   assign palette = st.palette;
   assign soft_reset_pulse = st.srst_req;
   assign bus.dev_data = st.dout;
   assign bus.dev_data_oe_n = st.doe_n;
endmodule

// *** hdl/lid_host.sv ***
// Purpose: Host controller end: turns APB commands into bus cycles.
// Assumes: Software waits for busy to clear before the next command.
// Notes: A command written while busy is dropped, so poll status first.
`timescale 1ns/100ps
module lid_host
   import lid_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Host bus
   lid_bus_if.host bus
);
   import lid_pkg::*;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_SETUP = 4'b0010,
      ST_STROBE = 4'b0100,
      ST_RECOVER = 4'b1000
   } lid_host_fsm_t;

   typedef struct packed {
      lid_host_fsm_t fsm;
      logic [7:0] cnt;
      logic [7:0] d_meta;
      logic [7:0] d_sync;
      logic is_read;
      logic [7:0] rdata;
      logic [9:0] cmd;
      logic cs_n;
      logic is_cmd;
      logic rd_n;
      logic wr_n;
      logic [7:0] dout;
      logic doe_n;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } lid_host_state_t;

   lid_host_state_t st;
   lid_host_state_t next_st;
   logic access;
   logic busy;

   assign access = psel && penable && !st.pready;
   assign busy = (st.fsm != ST_IDLE);

   always_comb
   begin
      next_st = st;
      next_st.d_meta = bus.data;
      next_st.d_sync = st.d_meta;
      next_st.pready = access;
      next_st.pslverr = 1'b0;
      if (st.cnt != 8'h00)
         next_st.cnt = st.cnt - 8'h01;
      if (access)
      begin
         next_st.prdata = 32'h0000_0000;
         if (paddr == HOST_CMD_OFS)
         begin
            next_st.prdata = {22'h0, st.cmd};
            if (pwrite && !busy)
            begin
               next_st.cmd = pwdata[9:0];
               next_st.is_read = pwdata[CMD_READ_BIT];
               next_st.is_cmd = pwdata[CMD_FLAG_BIT];
               next_st.cs_n = 1'b0;
               next_st.dout = pwdata[7:0];
               next_st.doe_n = pwdata[CMD_READ_BIT];
               next_st.fsm = ST_SETUP;
               next_st.cnt = 8'(SETUP_CYCLES - 1);
            end
         end
         else if (paddr == HOST_STATUS_OFS)
            next_st.prdata = {23'h0, busy, st.rdata};
         else
            next_st.pslverr = 1'b1;
      end
      case (st.fsm)
         ST_SETUP:
            if (st.cnt == 8'h00)
            begin
               // Read and write strobes are never low together.
               next_st.rd_n = !st.is_read;
               next_st.wr_n = st.is_read;
               next_st.fsm = ST_STROBE;
               next_st.cnt = 8'(STROBE_CYCLES - 1);
            end
         ST_STROBE:
            if (st.cnt == 8'h00)
            begin
               if (st.is_read)
                  next_st.rdata = st.d_sync;
               next_st.rd_n = 1'b1;
               next_st.wr_n = 1'b1;
               next_st.fsm = ST_RECOVER;
               next_st.cnt = 8'(RECOVER_CYCLES - 1);
            end
         ST_RECOVER:
            if (st.cnt == 8'h00)
            begin
               next_st.cs_n = 1'b1;
               next_st.doe_n = 1'b1;
               next_st.fsm = ST_IDLE;
            end
         // Idle keeps whatever the bus decode above has set up.
         default:
         begin
         end
      endcase
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st <= '0;
         st.fsm <= ST_IDLE;
         st.cs_n <= 1'b1;
         st.rd_n <= 1'b1;
         st.wr_n <= 1'b1;
         st.doe_n <= 1'b1;
         st.d_meta <= 8'hff;
         st.d_sync <= 8'hff;
      end
      else if (clk_en)
      begin
         st <= next_st;
      end
   end

   assign prdata = st.prdata;
   assign pready = st.pready;
   assign pslverr = st.pslverr;
   assign bus.chip_select_n = st.cs_n;
   assign bus.cmd_or_data_flag = st.is_cmd;
   assign bus.read_strobe_n = st.rd_n;
   assign bus.write_strobe_n = st.wr_n;
   assign bus.host_data = st.dout;
   assign bus.host_data_oe_n = st.doe_n;
endmodule

// *** dv/lid_assertions.sv ***
// Purpose: Wire-level checks on the host bus between the two ends.
// Assumes: One clock; clk_en is only lowered while the strobes are idle.
// Notes: Cycle counts follow the host's strobe timing of the link.
`timescale 1ns/100ps
module lid_assertions
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Bus signals
   input wire logic chip_select_n,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic [7:0] host_data,
   input wire logic host_data_oe_n,
   input wire logic dev_data_oe_n
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   sequence s_wr_low;
      !write_strobe_n [*8] ##1 write_strobe_n;
   endsequence
   sequence s_hold;
      (!chip_select_n && $stable(host_data)) [*4];
   endsequence

   property p_no_overlap;
      !(!read_strobe_n && !write_strobe_n);
   endproperty
   property p_wr_selected;
      !write_strobe_n |-> !chip_select_n;
   endproperty
   property p_wr_driven;
      !write_strobe_n |-> !host_data_oe_n && $stable(host_data);
   endproperty
   property p_rd_released;
      !read_strobe_n |-> host_data_oe_n;
   endproperty
   property p_no_fight;
      !dev_data_oe_n |-> host_data_oe_n;
   endproperty
   property p_wr_width;
      $fell(write_strobe_n) |-> s_wr_low;
   endproperty
   property p_rd_width;
      $fell(read_strobe_n) |-> !read_strobe_n [*8] ##1 read_strobe_n;
   endproperty
   property p_setup;
      $fell(write_strobe_n) |-> $past(chip_select_n, 2) == 1'b0;
   endproperty
   property p_recover;
      $rose(write_strobe_n) |-> s_hold;
   endproperty
   property p_dev_answer;
      $fell(read_strobe_n) |-> ##[1:6] !dev_data_oe_n;
   endproperty

   a_no_overlap: assert property (p_no_overlap)
      else $error("Read and write strobes low together");
   a_wr_selected: assert property (p_wr_selected)
      else $error("Write strobe without chip select");
   a_wr_driven: assert property (p_wr_driven)
      else $error("Host data not held during write strobe");
   a_rd_released: assert property (p_rd_released)
      else $error("Host drives data during read strobe");
   a_no_fight: assert property (p_no_fight)
      else $error("Both ends drive the data bus");
   a_wr_width: assert property (p_wr_width)
      else $error("Write strobe width wrong");
   a_rd_width: assert property (p_rd_width)
      else $error("Read strobe width wrong");
   a_setup: assert property (p_setup)
      else $error("Chip select setup too short");
   a_recover: assert property (p_recover)
      else $error("Select or data released too early");
   a_dev_answer: assert property (p_dev_answer)
      else $error("Driver end did not answer a read");
endmodule

// *** dv/tb.sv ***
// Purpose: Self-checking bench for the host and driver ends of the link.
// Assumes: Both ends share clk; commands reach the host over APB.
// Notes: Status is polled after each send; only reset and t_freeze use fixed waits.
`timescale 1ns/100ps
module tb;
   import lid_pkg::*;
   logic clk, reset_n, clk_en, psel, penable, pwrite, pready, pslverr;
   logic [31:0] paddr, pwdata, prdata;
   logic [7:0] disp_rd_data, disp_wr_data, wr_seen, st;
   logic disp_wr_pulse, disp_rd_pulse, srst_pulse;
   lid_cfg_t cfg, exp_cfg;
   logic [PAL_ENTRIES-1:0][4:0] palette;
   int n_mismatch, checks_done, n_wr, n_rd, n_srst;
   lid_bus_if bus();
   lid_host i_lid_host(.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .bus(bus.host));
   lid_device i_lid_device(.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
      .bus(bus.device), .display_read_data(disp_rd_data),
      .display_write_pulse(disp_wr_pulse), .display_write_data(disp_wr_data),
      .display_read_pulse(disp_rd_pulse), .cfg(cfg), .palette(palette),
      .soft_reset_pulse(srst_pulse));
   lid_assertions u_chk(.clk(clk), .reset_n(reset_n),
      .chip_select_n(bus.chip_select_n), .read_strobe_n(bus.read_strobe_n),
      .write_strobe_n(bus.write_strobe_n), .host_data(bus.host_data),
      .host_data_oe_n(bus.host_data_oe_n), .dev_data_oe_n(bus.dev_data_oe_n));

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk)
   begin
      if (disp_wr_pulse)
      begin
         n_wr++;
         wr_seen = disp_wr_data;
      end
      if (disp_rd_pulse)
         n_rd++;
      if (srst_pulse)
         n_srst++;
   end

   task automatic chk(input string what, input logic [79:0] e,
                      input logic [79:0] g);
      checks_done++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic tally_and_finish();
      if (n_mismatch == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Starts on an edge of its own so psel is never assigned twice at once.
   task automatic apb(input logic wr, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic err);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for the answer.
      do
      begin
         @(posedge clk);
      end
      while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic send(input logic [7:0] b, input logic cmd, input logic rd);
      logic [31:0] q;
      logic e;
      int n;
      apb(1'b1, HOST_CMD_OFS, {22'h0, rd, cmd, b}, q, e);
      n = 0;
      do
      begin
         apb(1'b0, HOST_STATUS_OFS, 32'h0, q, e);
         n++;
      end
      while (q[STATUS_BUSY_BIT] !== 1'b0 && n < 40);
      chk("busy", 80'h0, 80'(q[STATUS_BUSY_BIT]));
      st = q[7:0];
   endtask

   task automatic t_reset();
      chk("cfg", 80'h0, 80'(cfg));
      for (int j = 0; j < PAL_ENTRIES; j++)
         chk("palette", (j % 16 == 0) ? 80'h0 : 80'({j[3:0], 1'b1}),
             80'(palette[j]));
   endtask

   task automatic t_table0();
      logic [3:0] d [15] = '{4'ha, 4'h5, 4'hc, 4'hf, 4'h3, 4'he, 4'h1,
                             4'h8, 4'ha, 4'hf, 4'h5, 4'h6, 4'h9, 4'hf, 4'hb};
      send(8'hf0, 1'b1, 1'b0);
      send({ADDR_WIN_COL_LO, d[0]}, 1'b1, 1'b0);
      chk("col_low", 80'h0a, 80'(cfg.win_start_col));
      for (int a = 1; a < 15; a++)
         send({a[3:0], d[a]}, 1'b1, 1'b0);
      exp_cfg = '0;
      exp_cfg.win_start_col = 8'h5a;
      exp_cfg.win_start_row = 7'h7c;
      exp_cfg.top_row_pointer = 7'h63;
      exp_cfg.inversion_count = 7'h01;
      {exp_cfg.com_scan_direction, exp_cfg.two_tone_select,
       exp_cfg.force_pixels_on, exp_cfg.display_enable} = 4'ha;
      {exp_cfg.invert_display, exp_cfg.line_group_inversion_en,
       exp_cfg.palette_exchange} = 3'h7;
      {exp_cfg.rmw_flag, exp_cfg.walk_axis, exp_cfg.col_step_dir,
       exp_cfg.row_step_dir} = 4'h5;
      {exp_cfg.bias_amp_enable, exp_cfg.halt,
       exp_cfg.booster_enable} = 3'h3;
      exp_cfg.duty_code = 4'h9;
      exp_cfg.boost_level_code = 3'h7;
      exp_cfg.bias_code = 3'h3;
      chk("cfg", 80'(exp_cfg), 80'(cfg));
      send({ADDR_POWER, 4'h7}, 1'b1, 1'b0);
      chk("soft_reset", 80'h1, 80'(n_srst));
      chk("cfg", 80'(exp_cfg), 80'(cfg));
   endtask

   task automatic t_palette();
      int tbl[4] = '{1, 2, 3, 4};
      int ad[4] = '{0, 2, 4, 4};
      int bk[4] = '{1, 0, 0, 1};
      int ix[4] = '{8, 16, 32, 47};
      for (int k = 0; k < 4; k++)
      begin
         send(8'hf5, 1'b1, 1'b0);
         send({ADDR_BANK_SEL, 3'h7, bk[k][0]}, 1'b1, 1'b0);
         chk("bank", 80'(bk[k]), 80'(cfg.palette_bank_select));
         send({5'h1e, tbl[k][2:0]}, 1'b1, 1'b0);
         send({ad[k][3:0], 4'ha ^ k[3:0]}, 1'b1, 1'b0);
         chk("pal_low", 80'(4'ha ^ k[3:0]), 80'(palette[ix[k]][3:0]));
         send({ad[k][3:0] + 4'h1, 3'h7, k[0]}, 1'b1, 1'b0);
         chk("pal", 80'({k[0], 4'ha ^ k[3:0]}), 80'(palette[ix[k]]));
         chk("pal_near", 80'({ix[k][3:0] - 4'h1, 1'b1}),
             80'(palette[ix[k] - 1]));
      end
   endtask

   task automatic t_contrast();
      send(8'hf4, 1'b1, 1'b0);
      send({ADDR_CONTRAST_HI, 4'hd}, 1'b1, 1'b0);
      chk("contrast_held", 80'h0, 80'(cfg.contrast_resistor));
      send({ADDR_CONTRAST_LO, 4'h3}, 1'b1, 1'b0);
      chk("contrast", 80'h53, 80'(cfg.contrast_resistor));
   endtask

   task automatic t_regread();
      send(8'hfb, 1'b1, 1'b0);
      chk("test_flag", 80'h1, 80'(cfg.test_flag));
      send(8'h00, 1'b1, 1'b1);
      chk("reg_read", 80'h0b, 80'(st));
      send(8'h07, 1'b1, 1'b0);
      chk("col_kept", 80'h5a, 80'(cfg.win_start_col));
      chk("pal_b14", 80'h7, 80'(palette[30][3:0]));
   endtask

   task automatic t_data();
      logic [31:0] q;
      logic e;
      send(8'h3c, 1'b0, 1'b0);
      chk("disp_wr_count", 80'h1, 80'(n_wr));
      chk("disp_wr", 80'h3c, 80'(wr_seen));
      send(8'h00, 1'b0, 1'b1);
      chk("disp_rd", 80'ha5, 80'(st));
      chk("disp_rd_count", 80'h1, 80'(n_rd));
      apb(1'b0, HOST_CMD_OFS, 32'h0, q, e);
      chk("cmd_back", 80'h200, 80'(q));
      apb(1'b0, 32'h0000_0010, 32'h0, q, e);
      chk("slverr", 80'h1, 80'(e));
   endtask

   // A low clock enable stalls both ends mid-command; a command written
   // while the host is still busy is dropped.
   task automatic t_freeze();
      logic [31:0] q;
      logic e;
      apb(1'b1, HOST_CMD_OFS, {22'h0, 1'b0, 1'b1, 8'hf2}, q, e);
      clk_en <= 1'b0;
      repeat (30) @(posedge clk);
      chk("frozen_select", 80'h0, 80'(bus.chip_select_n));
      chk("frozen_table", 80'h3, 80'(cfg.table_index));
      clk_en <= 1'b1;
      send(8'hf1, 1'b1, 1'b0);
      chk("busy_drop", 80'h2, 80'(cfg.table_index));
   endtask

   initial
   begin
      clk_en = 1'b1;
      reset_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      disp_rd_data = 8'ha5;
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      t_reset();
      t_table0();
      t_palette();
      t_contrast();
      t_regread();
      t_data();
      t_freeze();
      tally_and_finish();
   end

   initial
   begin
      #100000;
      n_mismatch++;
      tally_and_finish();
   end
endmodule
